// File: src/fspc_pkg.sv
package fspc_pkg;
  localparam int PC_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_FIELD_W = 13;
  localparam int OPC_W = 3;
  localparam int STK_DEPTH = 16;
  localparam int SP_W = 5;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [PC_W-1:0] VEC_EXT0 = 16'h0004;
  localparam logic [PC_W-1:0] VEC_EXT1 = 16'h0008;
  localparam logic [PC_W-1:0] VEC_TMR0 = 16'h000C;
  localparam logic [PC_W-1:0] VEC_TMR1 = 16'h0010;
  localparam logic [PC_W-1:0] VEC_SER = 16'h0014;
  localparam logic [PC_W-1:0] VEC_MULTI = 16'h0018;
  localparam int NUM_IRQ = 6;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam logic [SP_W-1:0] SP_RST = 5'h00;
  // variant program counter widths selected by pc_width_sel
  localparam logic [1:0] PCW_14 = 2'h0;
  localparam logic [1:0] PCW_15 = 2'h1;
  localparam logic [1:0] PCW_16 = 2'h2;
  localparam logic [PC_W-1:0] PC_MASK_14 = 16'h3FFF;
  localparam logic [PC_W-1:0] PC_MASK_15 = 16'h7FFF;
  localparam logic [PC_W-1:0] PC_MASK_16 = 16'hFFFF;
  // flow operation issued by the decoder at the end of the fourth phase
  typedef enum logic [OPC_W-1:0] {
    FSPC_OP_NONE, FSPC_OP_JUMP, FSPC_OP_CALL, FSPC_OP_SUB_EXIT,
    FSPC_OP_INT_EXIT, FSPC_OP_SKIP, FSPC_OP_PCL_WR
  } fspc_op_e;
endpackage

// File: src/fspc_core.sv
`timescale 1ns/100ps
// What this block does
// RULE1: four phases from sys_clk make one instruction cycle
// RULE2: pc advances and fetch occurs in phase one
// RULE3: phases two to four decode and execute
// RULE4: fetch overlaps execute; flow changes cost one cycle
// RULE5: rc mode drives phase-one clock, 1:3 duty
// RULE6: pc increments by one unless flow jumps
// RULE7: only pc low byte readable and writable
// RULE8: taken skip discards prefetched word, dummy cycle
// RULE9: low byte write keeps upper bits, same page
// RULE10: low byte write inserts one dummy cycle
// RULE11: jumps, calls, interrupts, reset load target address
// RULE12: reset zero; vectors 0x004, 0x008, 0x00C
// RULE13: vectors 0x010, 0x014, 0x018, upper bits cleared
// RULE14: all data operations use one 8-bit alu
// RULE15: jump target top bits from bank pointer 7..5
// RULE16: pc width 16, 15 or 14 bits
// RULE17: call or interrupt pushes pc first
// RULE18: returns restore pc from stack
module fspc_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rc_osc_mode,
  input wire logic [1:0] pc_width_sel,
  input wire fspc_pkg::fspc_op_e flow_op,
  input wire logic skip_taken,
  input wire logic [fspc_pkg::ADDR_FIELD_W-1:0] addr_field,
  input wire logic [fspc_pkg::BYTE_W-1:0] bank_pointer,
  input wire logic [fspc_pkg::NUM_IRQ-1:0] irq_req,
  input wire logic [fspc_pkg::BYTE_W-1:0] reg_addr_unused_free,
  input wire logic pc_low_byte_wr,
  input wire logic pc_low_byte_rd,
  input wire logic [fspc_pkg::BYTE_W-1:0] pc_low_byte_wdata,
  output logic [fspc_pkg::BYTE_W-1:0] pc_low_byte_rdata,
  output logic [fspc_pkg::PC_W-1:0] fetch_addr,
  output logic fetch_en,
  output logic [3:0] four_instruction_phases,
  output logic exec_en,
  output logic dummy_cycle,
  output logic [fspc_pkg::NUM_IRQ-1:0] irq_ack,
  output logic stack_full,
  output logic second_oscillator_pin_o,
  output logic second_oscillator_pin_oe
);
  import fspc_pkg::*;

  logic [1:0] phase_r;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [PC_W-1:0] stack_r [STK_DEPTH];
  logic [SP_W-1:0] sp_r, sp_nxt;
  logic dummy_r, dummy_nxt;
  logic [BYTE_W-1:0] rdata_r;
  logic [NUM_IRQ-1:0] ack_r;
  logic osc_r;

  function automatic logic [PC_W-1:0] vec_of(input logic [NUM_IRQ-1:0] req);
    logic [PC_W-1:0] v;
    v = PC_RST;
    if (req[0]) v = VEC_EXT0; // RULE12
    else if (req[1]) v = VEC_EXT1; // RULE12
    else if (req[2]) v = VEC_TMR0; // RULE12
    else if (req[3]) v = VEC_TMR1; // RULE13
    else if (req[4]) v = VEC_SER; // RULE13
    else if (req[5]) v = VEC_MULTI; // RULE13
    return v;
  endfunction

  function automatic logic [NUM_IRQ-1:0] first_of(input logic [NUM_IRQ-1:0] req);
    return req & (~req + 6'h01);
  endfunction

  // end of the fourth phase is where the executed instruction commits flow
  wire phase_end = (phase_r == PHASE_LAST); // RULE1
  wire [PC_W-1:0] pc_mask = (pc_width_sel == PCW_14) ? PC_MASK_14 :
                            (pc_width_sel == PCW_15) ? PC_MASK_15 : PC_MASK_16; // RULE16
  wire [PC_W-1:0] pc_inc = pc_r + PC_STEP; // RULE6
  wire [PC_W-1:0] jump_tgt = {bank_pointer[7:5], addr_field}; // RULE15
  wire [PC_W-1:0] pcl_tgt = {pc_r[PC_W-1:BYTE_W], pc_low_byte_wdata}; // RULE9
  wire [SP_W-1:0] stk_top = 5'(STK_DEPTH);
  wire full_w = (sp_r == stk_top);
  // interrupts wait while the stack is full or a dummy cycle is pending
  wire irq_go = phase_end && (|irq_req) && !full_w && !dummy_r &&
                (flow_op == FSPC_OP_NONE) && !skip_taken && !pc_low_byte_wr;
  wire [NUM_IRQ-1:0] irq_sel = first_of(irq_req);
  wire push_w = phase_end && !dummy_r && ((flow_op == FSPC_OP_CALL) || irq_go); // RULE17
  wire pop_w = phase_end && !dummy_r && (sp_r != SP_RST) &&
               ((flow_op == FSPC_OP_SUB_EXIT) || (flow_op == FSPC_OP_INT_EXIT)); // RULE18
  wire [SP_W-1:0] pop_idx = sp_r - 5'h01;

  always_comb begin
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    dummy_nxt = dummy_r;
    if (phase_end) begin
      dummy_nxt = 1'b0;
      if (dummy_r) begin
        pc_nxt = pc_inc; // RULE4
      end else if (irq_go) begin
        pc_nxt = vec_of(irq_sel); // RULE11
        sp_nxt = sp_r + 5'h01;
        dummy_nxt = 1'b1;
      end else if (pc_low_byte_wr) begin
        pc_nxt = pcl_tgt; // RULE9
        dummy_nxt = 1'b1; // RULE10
      end else begin
        case (flow_op)
          FSPC_OP_JUMP: begin
            pc_nxt = jump_tgt; // RULE11
            dummy_nxt = 1'b1; // RULE4
          end
          FSPC_OP_CALL: begin
            pc_nxt = jump_tgt; // RULE11
            if (!full_w) sp_nxt = sp_r + 5'h01;
            dummy_nxt = 1'b1;
          end
          FSPC_OP_SUB_EXIT, FSPC_OP_INT_EXIT: begin
            if (pop_w) begin
              pc_nxt = stack_r[pop_idx[3:0]]; // RULE18
              sp_nxt = pop_idx;
            end
            dummy_nxt = 1'b1;
          end
          default: begin
            pc_nxt = pc_inc; // RULE6
            if (skip_taken) dummy_nxt = 1'b1; // RULE8
          end
        endcase
      end
    end
    pc_nxt = pc_nxt & pc_mask; // RULE16
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_r <= PHASE_RST;
      pc_r <= PC_RST; // RULE12
      sp_r <= SP_RST;
      dummy_r <= 1'b0;
    end else begin
      phase_r <= phase_r + 2'h1; // RULE1
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      dummy_r <= dummy_nxt;
    end
  end

  // stack holds return addresses only; an overflowing call is not pushed and the stack pointer stays at the top
  always_ff @(posedge sys_clk) begin
    if (push_w && !full_w) begin
      stack_r[sp_r[3:0]] <= (irq_go ? pc_r : pc_r) & pc_mask; // RULE17
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      ack_r <= '0;
      osc_r <= 1'b0;
    end else begin
      rdata_r <= pc_low_byte_rd ? pc_r[BYTE_W-1:0] : 8'h00; // RULE7
      ack_r <= irq_go ? irq_sel : '0;
      osc_r <= phase_end; // RULE5
    end
  end

  // prefetched word is addressed by pc during phase one of every cycle
  assign fetch_addr = pc_r; // RULE2
  assign fetch_en = (phase_r == PHASE_RST); // RULE2
  assign exec_en = (phase_r != PHASE_RST) && !dummy_r; // RULE3
  assign dummy_cycle = dummy_r; // RULE8
  assign four_instruction_phases = 4'h1 << phase_r; // RULE1
  assign pc_low_byte_rdata = rdata_r; // RULE7
  assign irq_ack = ack_r;
  assign stack_full = full_w;
  // high exactly during phase one: one part high, three low
  assign second_oscillator_pin_o = osc_r; // RULE5
  assign second_oscillator_pin_oe = rc_osc_mode; // RULE5
  // data operations run in an external 8-bit alu; only pc flow lives here RULE14
endmodule

// File: verification/fspc_irq_src.sv
`timescale 1ns/100ps
module fspc_irq_src (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] raise,
  input wire logic [5:0] irq_ack,
  output logic [5:0] irq_req
);
  // a request stays latched until acknowledged, as a real flag would
  always_ff @(posedge sys_clk) begin
    if (rst) irq_req <= 6'h00;
    else irq_req <= (irq_req | raise) & ~irq_ack;
  end
endmodule

// File: verification/fspc_chk_assertions.sv
`timescale 1ns/100ps
module fspc_chk import fspc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fspc_pkg::fspc_op_e flow_op,
  input wire logic skip_taken,
  input wire logic [5:0] irq_req,
  input wire logic pc_low_byte_wr,
  input wire logic pc_low_byte_rd,
  input wire logic [7:0] pc_low_byte_wdata,
  input wire logic [7:0] pc_low_byte_rdata,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_en,
  input wire logic [3:0] four_instruction_phases,
  input wire logic exec_en,
  input wire logic dummy_cycle
);
  logic [3:0] ph;
  logic calm;
  assign ph = four_instruction_phases;
  // nothing of higher priority than the decoder's op at this edge
  assign calm = ph[3] && !dummy_cycle && irq_req == 6'h00 && !pc_low_byte_wr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_PHASE: assert property (ph[0] |=> ph[1] ##1 ph[2] ##1 ph[3] ##1 ph[0])
    else $error("phase order");
  AST_FETCH: assert property (fetch_en == ph[0]) else $error("fetch phase");
  AST_EXEC: assert property (exec_en |-> !ph[0] && !dummy_cycle) else $error("exec");
  AST_HOLD: assert property (!ph[3] |=> $stable(fetch_addr)) else $error("pc moved");
  AST_INC: assert property (calm && flow_op == FSPC_OP_NONE && !skip_taken
    |=> fetch_addr == $past(fetch_addr) + PC_STEP) else $error("pc step");
  AST_PCL: assert property (ph[3] && !dummy_cycle && irq_req == 6'h00 && pc_low_byte_wr
    |=> dummy_cycle && fetch_addr == {$past(fetch_addr[15:8]), $past(pc_low_byte_wdata)})
    else $error("low byte write");
  AST_RD: assert property (pc_low_byte_rd |=> pc_low_byte_rdata == $past(fetch_addr[7:0]))
    else $error("low byte read");
  AST_DUMMY: assert property ($rose(dummy_cycle) |-> ph[0] ##0 dummy_cycle [*4])
    else $error("dummy length");
endmodule
bind fspc_core fspc_chk u_chk (.*);

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import fspc_pkg::*;
  typedef struct {fspc_op_e op; logic sk; logic [12:0] ad; int kd; logic du;} fspc_row_s;
  logic sys_clk = 0, rst = 1, skip_taken = 0, pc_low_byte_wr = 0, pc_low_byte_rd = 0;
  logic fetch_en, exec_en, dummy_cycle, stack_full, second_oscillator_pin_o;
  logic second_oscillator_pin_oe, rc_osc_mode = 1;
  logic [7:0] pc_low_byte_wdata = 0, pc_low_byte_rdata, reg_addr_unused_free = 0;
  logic [7:0] bank_pointer = 8'hA0;
  logic [12:0] addr_field = 0;
  logic [5:0] irq_req, irq_ack, ak, raise = 0;
  logic [3:0] four_instruction_phases;
  logic [15:0] fetch_addr, pc = 0, sv = 0;
  logic [1:0] pc_width_sel = 2'h2;
  fspc_op_e flow_op = FSPC_OP_NONE;
  int errors = 0, total_checks = 0;
  fspc_row_s rows [9] = '{
    '{FSPC_OP_NONE, 0, 0, 0, 0}, '{FSPC_OP_JUMP, 0, 13'h1ABC, 1, 1},
    '{FSPC_OP_SKIP, 1, 0, 0, 1}, '{FSPC_OP_SKIP, 0, 0, 0, 0},
    '{FSPC_OP_PCL_WR, 0, 13'h00A5, 2, 1}, '{FSPC_OP_CALL, 0, 13'h0123, 1, 1},
    '{FSPC_OP_SUB_EXIT, 0, 0, 3, 1}, '{FSPC_OP_JUMP, 0, 13'h1FFF, 1, 1},
    '{FSPC_OP_NONE, 0, 0, 0, 0}};
  always #50 sys_clk = ~sys_clk;
  fspc_core DUT (.*);
  fspc_irq_src u_src (.*);
  task automatic print_verdict();
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(logic ok, string m);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic step(fspc_row_s r);
    int n;
    n = 0;
    // look at the phase where it has settled, then drive on the edge that ends phase three
    do begin
      @(negedge sys_clk);
      n++;
    end while (!(four_instruction_phases[2] && !dummy_cycle) && n < 40);
    if (n >= 40) begin
      chk(0, "timeout");
      print_verdict();
    end
    @(posedge sys_clk);
    flow_op <= r.op;
    skip_taken <= r.sk;
    addr_field <= r.ad;
    pc_low_byte_wdata <= r.ad[7:0];
    pc_low_byte_wr <= r.op == FSPC_OP_PCL_WR;
    @(posedge sys_clk);
    flow_op <= FSPC_OP_NONE;
    pc_low_byte_wr <= 0;
    pc_low_byte_rd <= 1;
    if (r.kd == 1 || r.kd == 4) sv = pc;
    case (r.kd)
      0: pc = pc + 16'h0001;
      1: pc = {3'h5, r.ad};
      2: pc[7:0] = r.ad[7:0];
      3: pc = sv;
      default: pc = 16'(r.ad);
    endcase
    @(negedge sys_clk);
    ak = irq_ack;
    chk(fetch_addr === pc, "pc");
    if (r.du !== 1'bx) chk(dummy_cycle === r.du, "dummy");
    chk(fetch_en === 1'b1 && exec_en === 1'b0 && stack_full === 1'b0, "fetch phase");
    chk(second_oscillator_pin_o === 1'b1 && second_oscillator_pin_oe === rc_osc_mode, "osc");
    @(posedge sys_clk);
    pc_low_byte_rd <= 0;
    @(negedge sys_clk);
    ak = ak | irq_ack;
    chk(pc_low_byte_rdata === pc[7:0], "read");
    chk(exec_en === !r.du && second_oscillator_pin_o === 1'b0, "exec phase");
    if (r.kd == 4) chk(ak === 6'h01 << (r.ad[4:2] - 3'h1), "ack");
    if (r.du === 1'b1) pc = pc + 16'h0001;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 0;
    @(negedge sys_clk);
    chk(fetch_addr === PC_RST && four_instruction_phases === 4'h1, "reset");
    foreach (rows[i]) step(rows[i]);
    // leave a dummy cycle running so the first request below is held off until its own step
    step('{FSPC_OP_JUMP, 0, 13'h0040, 1, 1});
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      raise <= 6'h01 << i;
      @(posedge sys_clk);
      raise <= 0;
      step('{FSPC_OP_NONE, 0, 13'(4 * i + 4), 4, 1});
      step('{FSPC_OP_INT_EXIT, 0, 0, 3, 1});
    end
    print_verdict();
  end
endmodule
